// ==== rtl/aah_alarm_ack_horn.sv ====
`timescale 1ns/1ps
// Function
// - Class B-F alarm starts flashing lamp, horn
// - Horn delay expiry: lamp steady, horn off
// - Lamp flashes until button, logic, interface ack
// - Zero horn delay: horn waits for ack
// - First remote pulse silences horn only
// - Second pulse clears inactive alarms only
// - Pulse accepted after on-delay high
// - Off-delay low before next pulse accepted
// - Lock condition suppresses lockable monitoring
// - Self-acknowledging alarm clears when fault gone
module aah_alarm_ack_horn
  import aah_pkg::*;
#(
  parameter int N_ALARM   = 8,
  parameter int N_DI      = 8,
  parameter int MS_CYCLES = AAH_MS_CYCLES
)(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [N_DI-1:0]    discrete_input,
  input  wire logic               button_ack,
  input  wire logic               logic_ack,
  input  wire logic [N_ALARM-1:0] fault_raw,
  output logic      [N_ALARM-1:0] fault_monitored,
  output logic      [N_ALARM-1:0] alarm_latched,
  output logic                    alarm_lamp,
  output logic                    horn
);

  // ******************************************************************
  // Configuration registers
  // ******************************************************************
  logic [9:0]         horn_delay;
  logic [15:0]        on_delay;
  logic [15:0]        off_delay;
  logic [7:0]         ack_sel;
  logic [7:0]         lock_sel;
  aah_alarm_cfg_t     cfg;

  // ******************************************************************
  // Bus decode
  // ******************************************************************
  wire        wr_en     = psel && penable && pwrite;
  wire        hit_hdly  = paddr == AAH_HORN_DELAY_OFS;
  wire        hit_on    = paddr == AAH_ON_DELAY_OFS;
  wire        hit_off   = paddr == AAH_OFF_DELAY_OFS;
  wire        hit_src   = paddr == AAH_SRC_SEL_OFS;
  wire        hit_ann   = paddr == AAH_ANNUNC_OFS;
  wire        hit_self  = paddr == AAH_SELF_ACK_OFS;
  wire        hit_lock  = paddr == AAH_LOCKABLE_OFS;
  wire        hit_cmd   = paddr == AAH_ACK_CMD_OFS;
  wire        hit_stat  = paddr == AAH_STATUS_OFS;
  wire        hit_alm   = paddr == AAH_ALARMS_OFS;
  wire        hit_any   = hit_hdly | hit_on | hit_off | hit_src | hit_ann | hit_self
                        | hit_lock | hit_cmd | hit_stat | hit_alm;
  wire        iface_full = wr_en && hit_cmd && pwdata[AAH_CMD_FULL_POS];
  wire        iface_horn = wr_en && hit_cmd && pwdata[AAH_CMD_HORN_POS];

  // Horn delay above the documented maximum is clipped
  wire [9:0]  hdly_wr   = (pwdata > 32'(AAH_HORN_MAX_S))
                          ? 10'(AAH_HORN_MAX_S) : pwdata[9:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      horn_delay   <= AAH_HORN_DELAY_RST;
      on_delay     <= AAH_ON_DELAY_RST;
      off_delay    <= AAH_OFF_DELAY_RST;
      ack_sel      <= AAH_ACK_SEL_RST;
      lock_sel     <= AAH_LOCK_SEL_RST;
      cfg          <= '0;
    end
    else if (wr_en)
    begin
      if (hit_hdly) horn_delay <= hdly_wr;
      if (hit_on)   on_delay   <= pwdata[15:0];
      if (hit_off)  off_delay  <= pwdata[15:0];
      if (hit_src)
      begin
        ack_sel  <= pwdata[7:0];
        lock_sel <= pwdata[AAH_SRC_LOCK_POS +: 8];
      end
      if (hit_ann)  cfg.annunc   <= pwdata;
      if (hit_self) cfg.self_ack <= pwdata;
      if (hit_lock) cfg.lockable <= pwdata;
    end
  end

  // ******************************************************************
  // Time base: 1 ms tick, 1 s tick
  // ******************************************************************
  logic [$clog2(MS_CYCLES+1)-1:0] pre_cnt;
  logic [9:0]                     ms_cnt;
  wire                            ms_tick  = pre_cnt == ($bits(pre_cnt))'(MS_CYCLES - 1);
  wire                            sec_tick = ms_tick && ms_cnt == 10'(AAH_MS_PER_SEC - 1);
  wire                            blink_on = ms_cnt < 10'(AAH_BLINK_HALF_MS);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_cnt <= '0;
      ms_cnt  <= '0;
    end
    else
    begin
      pre_cnt <= ms_tick ? '0 : pre_cnt + 1'b1;
      if (ms_tick)
        ms_cnt <= sec_tick ? '0 : ms_cnt + 1'b1;
    end
  end

  // ******************************************************************
  // Condition selection and monitoring lock
  // ******************************************************************
  function automatic logic sel_any(input logic [N_DI-1:0] di, input logic [7:0] mask);
    sel_any = |(di & mask[N_DI-1:0]);
  endfunction

  wire                ack_cond  = sel_any(discrete_input, ack_sel);
  wire                lock_cond = sel_any(discrete_input, lock_sel);
  wire [N_ALARM-1:0]  lock_mask = {N_ALARM{lock_cond}} & cfg.lockable[N_ALARM-1:0];
  wire [N_ALARM-1:0]  fault_eff = fault_raw & ~lock_mask;

  // ******************************************************************
  // Acknowledge pulse filter
  // ******************************************************************
  aah_filt_t   filt;
  aah_filt_t   next_filt;
  logic [15:0] filt_cnt;
  logic        pulse_ok;

  always_comb
  begin
    next_filt = filt;
    pulse_ok  = 1'b0;
    unique case (filt)
      AAH_ARMED:
        if (ack_cond)
          next_filt = AAH_ON_WAIT;
      AAH_ON_WAIT:
        if (!ack_cond)
          next_filt = AAH_ARMED;
        else if (filt_cnt >= on_delay)
        begin
          next_filt = AAH_HELD;
          pulse_ok  = 1'b1;
        end
      AAH_HELD:
        if (!ack_cond)
          next_filt = AAH_OFF_WAIT;
      AAH_OFF_WAIT:
        if (ack_cond)
          next_filt = AAH_HELD;
        else if (filt_cnt >= off_delay)
          next_filt = AAH_ARMED;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filt     <= AAH_ARMED;
      filt_cnt <= '0;
    end
    else
    begin
      filt <= next_filt;
      // Counter saturates, so a long hold never wraps into a rearm
      if (next_filt != filt)
        filt_cnt <= '0;
      else if (ms_tick && filt_cnt != 16'hFFFF)
        filt_cnt <= filt_cnt + 1'b1;
    end
  end

  // ******************************************************************
  // Alarm latches
  // ******************************************************************
  logic [N_ALARM-1:0] fault_prev;
  logic               pulse_stage;
  wire  [N_ALARM-1:0] fault_rise = fault_eff & ~fault_prev;
  wire                new_alarm  = |(fault_rise & cfg.annunc[N_ALARM-1:0]);
  wire                remote_full = pulse_ok && pulse_stage;
  wire                remote_horn = pulse_ok && !pulse_stage;
  wire                full_ack   = button_ack || logic_ack || iface_full
                                   || remote_full;
  wire [N_ALARM-1:0]  auto_clr   = ~fault_eff & cfg.self_ack[N_ALARM-1:0];
  wire [N_ALARM-1:0]  ack_clr    = {N_ALARM{full_ack}} & ~fault_eff;
  // Set wins over any clear in the same cycle
  wire [N_ALARM-1:0]  next_latched = fault_rise | (alarm_latched & ~(auto_clr | ack_clr));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_prev    <= '0;
      alarm_latched <= '0;
    end
    else
    begin
      fault_prev    <= fault_eff;
      alarm_latched <= next_latched;
    end
  end

  // ******************************************************************
  // Horn, lamp and acknowledge sequence
  // ******************************************************************
  logic       flashing;
  logic [9:0] horn_secs;
  // Seconds counted only while sounding; a silenced horn keeps the lamp flashing
  wire        horn_expired = horn_delay != '0 && horn_secs >= horn_delay;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      horn        <= 1'b0;
      flashing    <= 1'b0;
      horn_secs   <= '0;
      pulse_stage <= 1'b0;
    end
    else if (new_alarm)
    begin
      horn        <= 1'b1;
      flashing    <= 1'b1;
      horn_secs   <= '0;
      pulse_stage <= 1'b0;
    end
    else
    begin
      if (full_ack || remote_horn || iface_horn || horn_expired)
        horn <= 1'b0;
      if (full_ack || horn_expired)
        flashing <= 1'b0;
      if (horn && sec_tick)
        horn_secs <= horn_secs + 1'b1;
      if (pulse_ok)
        pulse_stage <= !pulse_stage;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      alarm_lamp <= 1'b0;
    else
      alarm_lamp <= (|alarm_latched) && (!flashing || blink_on);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_monitored <= '0;
    else
      fault_monitored <= fault_eff;
  end

  // ******************************************************************
  // Read path
  // ******************************************************************
  wire [31:0] status_word = 32'({pulse_stage, ack_cond, lock_cond, flashing, alarm_lamp, horn});
  wire [31:0] rd_mux =
      hit_hdly ? 32'(horn_delay) :
      hit_on   ? 32'(on_delay) :
      hit_off  ? 32'(off_delay) :
      hit_src  ? {16'h0000, lock_sel, ack_sel} :
      hit_ann  ? cfg.annunc :
      hit_self ? cfg.self_ack :
      hit_lock ? cfg.lockable :
      hit_stat ? status_word :
      hit_alm  ? 32'(alarm_latched) : 32'h0000_0000;

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // Latched in setup, so read data stands through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

endmodule

// ==== rtl/aah_pkg.sv ====
package aah_pkg;

  // ******************************************************************
  // Register map (byte addresses)
  // ******************************************************************
  localparam logic [7:0] AAH_HORN_DELAY_OFS = 8'h00;
  localparam logic [7:0] AAH_ON_DELAY_OFS   = 8'h04;
  localparam logic [7:0] AAH_OFF_DELAY_OFS  = 8'h08;
  localparam logic [7:0] AAH_SRC_SEL_OFS    = 8'h0C;
  localparam logic [7:0] AAH_ANNUNC_OFS     = 8'h10;
  localparam logic [7:0] AAH_SELF_ACK_OFS   = 8'h14;
  localparam logic [7:0] AAH_LOCKABLE_OFS   = 8'h18;
  localparam logic [7:0] AAH_ACK_CMD_OFS    = 8'h1C;
  localparam logic [7:0] AAH_STATUS_OFS     = 8'h20;
  localparam logic [7:0] AAH_ALARMS_OFS     = 8'h24;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int AAH_SRC_LOCK_POS   = 8;
  localparam int AAH_CMD_FULL_POS   = 0;
  localparam int AAH_CMD_HORN_POS   = 1;
  localparam int AAH_ST_HORN_POS    = 0;
  localparam int AAH_ST_LAMP_POS    = 1;
  localparam int AAH_ST_FLASH_POS   = 2;
  localparam int AAH_ST_LOCK_POS    = 3;
  localparam int AAH_ST_ACKCND_POS  = 4;
  localparam int AAH_ST_STAGE_POS   = 5;

  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic [9:0]  AAH_HORN_DELAY_RST = 10'h000;
  localparam logic [15:0] AAH_ON_DELAY_RST   = 16'h0000;
  localparam logic [15:0] AAH_OFF_DELAY_RST  = 16'h0000;
  localparam logic [7:0]  AAH_ACK_SEL_RST    = 8'h02;
  localparam logic [7:0]  AAH_LOCK_SEL_RST   = 8'h01;

  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int AAH_CLK_HZ        = 10_000_000;
  localparam int AAH_TICK_MS       = 1;
  localparam int AAH_MS_CYCLES     = (AAH_CLK_HZ / 1000) * AAH_TICK_MS;
  localparam int AAH_MS_PER_SEC    = 1000;
  localparam int AAH_BLINK_HALF_MS = 500;
  localparam int AAH_HORN_MAX_S    = 1000;

  typedef enum logic [1:0] {
    AAH_ARMED,
    AAH_ON_WAIT,
    AAH_HELD,
    AAH_OFF_WAIT
  } aah_filt_t;

  // Per-alarm configuration travels together
  typedef struct packed {
    logic [31:0] annunc;
    logic [31:0] self_ack;
    logic [31:0] lockable;
  } aah_alarm_cfg_t;

endpackage

// ==== test/aah_chk.sv ====
`timescale 1ns/1ps
module aah_chk #(
  parameter int N_ALARM = 8
)(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr,
  input wire logic [N_ALARM-1:0] fault_raw,
  input wire logic [N_ALARM-1:0] fault_monitored,
  input wire logic [N_ALARM-1:0] alarm_latched,
  input wire logic               alarm_lamp,
  input wire logic               horn
);
  wire acc = psel & penable;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_bad_addr: assert property (acc && paddr > 8'h24 |-> pslverr)
    else $error("unmapped access without error");
  a_err_access: assert property (!acc |-> !pslverr)
    else $error("error outside access phase");
  a_rdata_hold: assert property (acc |=> $stable(prdata))
    else $error("read data moved in access phase");
  a_mon_source: assert property ((fault_monitored & ~$past(fault_raw)) == '0)
    else $error("monitored fault without raw fault");
  a_latch_cause: assert property (((alarm_latched & ~$past(alarm_latched)) & ~fault_monitored) == '0)
    else $error("alarm latched without fault");
  a_clear_inactive: assert property ((~alarm_latched & $past(alarm_latched) & fault_monitored) == '0)
    else $error("active alarm cleared");
  a_lamp_cause: assert property (alarm_lamp |-> $past(alarm_latched) != '0)
    else $error("lamp lit with no alarm");
  a_horn_cause: assert property ($rose(horn) |-> alarm_latched != '0)
    else $error("horn without alarm");
endmodule

bind aah_alarm_ack_horn aah_chk #(.N_ALARM(N_ALARM)) u_chk (.*);

// ==== test/aah_far_model.sv ====
`timescale 1ns/1ps
module aah_far_model (
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic [7:0] len,
  input  wire logic       lock,
  output logic      [7:0] discrete_input
);
  logic [7:0] left  = 8'h00;
  logic [5:0] noise = 6'h00;
  // Unselected inputs toggle, so a wrong default mask shows
  assign discrete_input = {noise, left != 8'h00, lock};
  always_ff @(posedge pclk)
  begin
    noise <= noise + 6'h01;
    if (go)
      left <= len;
    else if (left != 8'h00)
      left <= left - 8'h01;
  end
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import aah_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, len = 8'h00, discrete_input;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, horn, alarm_lamp, go = 1'b0, lock = 1'b0;
  logic        button_ack = 1'b0, logic_ack = 1'b0;
  logic [7:0]  fault_raw = 8'h00, fault_monitored, alarm_latched;
  logic [2:0]  b, c;
  int          errors = 0, checks = 0;
  logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h24, 8'h30};
  logic [31:0] rx[6] = '{32'h0, 32'h0, 32'h0, 32'h102, 32'h0, 32'h0};

  always #50 pclk = ~pclk;

  aah_alarm_ack_horn #(.MS_CYCLES(10)) DUT (.*);
  aah_far_model FAR (.*);

  function automatic logic [7:0] bm(input logic [2:0] x);
    return 8'h01 << x;
  endfunction

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic flt(input logic [2:0] x, input logic v);
    fault_raw[x] <= v;
    wt(3);
  endtask

  task automatic pulse(input logic [7:0] n, input int gap);
    go <= 1'b1;
    len <= n;
    @(posedge pclk);
    go <= 1'b0;
    wt(n + gap);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge pclk);
    errors++;
    $display("FAIL %0t watchdog expired", $time);
    finish_test();
  end

  initial
  begin
    void'($urandom(32'h7FFD));
    wt(4);
    presetn <= 1'b1;
    foreach (ra[i])
    begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rx[i]);
      chk(32'(er), 32'(ra[i] == 8'h30));
    end
    apb(1'b1, AAH_ANNUNC_OFS, 32'hFF);
    apb(1'b1, AAH_HORN_DELAY_OFS, 32'h2);
    apb(1'b1, AAH_ON_DELAY_OFS, 32'h3);
    apb(1'b1, AAH_OFF_DELAY_OFS, 32'h3);
    b = 3'($urandom);
    c = b + 3'h1;
    flt(b, 1'b1);
    chk(32'(horn), 32'h1);
    apb(1'b0, AAH_STATUS_OFS, 32'h0);
    chk(32'(rd[AAH_ST_FLASH_POS]), 32'h1);
    chk(32'(rd[AAH_ST_HORN_POS]), 32'h1);
    wt(9000);
    chk(32'(horn), 32'h1);
    wt(11100);
    chk(32'(horn), 32'h0);
    apb(1'b0, AAH_STATUS_OFS, 32'h0);
    chk(32'(rd[AAH_ST_FLASH_POS]), 32'h0);
    chk(32'(rd[AAH_ST_LAMP_POS]), 32'h1);
    chk(32'(rd[AAH_ST_HORN_POS]), 32'h0);
    apb(1'b1, AAH_HORN_DELAY_OFS, 32'h0);
    flt(c, 1'b1);
    wt(20100);
    chk(32'(horn), 32'h1);
    flt(b, 1'b0);
    // Too short, then accepted, then rearmed too early
    pulse(8'h14, 60);
    chk(32'(horn), 32'h1);
    pulse(8'h28, 10);
    chk(32'(horn), 32'h0);
    chk(32'(alarm_latched), 32'(bm(b) | bm(c)));
    apb(1'b0, AAH_STATUS_OFS, 32'h0);
    chk(32'(rd[AAH_ST_FLASH_POS]), 32'h1);
    pulse(8'h28, 60);
    chk(32'(alarm_latched), 32'(bm(b) | bm(c)));
    pulse(8'h23 + 8'($urandom % 16), 10);
    chk(32'(alarm_latched), 32'(bm(c)));
    for (int k = 0; k < 3; k++)
    begin
      flt(c + 3'h1 + 3'(k), 1'b1);
      flt(c + 3'h1 + 3'(k), 1'b0);
      chk(32'(horn), 32'h1);
      if (k == 2)
      begin
        // Interface horn silence alone keeps every alarm
        apb(1'b1, AAH_ACK_CMD_OFS, 32'h2);
        wt(2);
        chk(32'(horn), 32'h0);
        chk(32'(alarm_latched), 32'(bm(c) | bm(c + 3'h3)));
      end
      case (k)
        0: button_ack <= 1'b1;
        1: logic_ack <= 1'b1;
        default: apb(1'b1, AAH_ACK_CMD_OFS, 32'h1);
      endcase
      wt(1);
      button_ack <= 1'b0;
      logic_ack <= 1'b0;
      wt(3);
      chk(32'(alarm_latched), 32'(bm(c)));
      chk(32'(horn), 32'h0);
      chk(32'(alarm_lamp), 32'h1);
    end
    apb(1'b1, AAH_SELF_ACK_OFS, 32'hFF);
    flt(b, 1'b1);
    flt(b, 1'b0);
    chk(32'(alarm_latched), 32'(bm(c)));
    apb(1'b1, AAH_LOCKABLE_OFS, 32'(bm(c)));
    flt(b, 1'b1);
    lock <= 1'b1;
    wt(6);
    chk(32'(fault_monitored), 32'(bm(b)));
    lock <= 1'b0;
    wt(6);
    chk(32'(fault_monitored), 32'(bm(b) | bm(c)));
    finish_test();
  end
endmodule
